// *** core/mms_defines.svh ***
// Constants for the measurement-mode select block.
// Assumes inclusion by bare name from core/ and dv/ files.
// How it works
// - 8-bit config register at address 0x0B
// - Bits 1:0 pick period phase
// - Bits 3:2 pick peak phase
// - Voltage over level sets voltage peak flag
// - Current over level sets current peak flag
// - Bits 6:4 enable phases for crossings
// - Bit4 A, bit5 B, bit6 C; reset 7
`ifndef MMS_DEFINES_SVH
`define MMS_DEFINES_SVH
`define MMS_ADDR_W        6
`define MMS_CFG_ADDR      6'h0B
`define MMS_CFG_RESET     8'h70
`define MMS_PERD_LSB      0
`define MMS_PEAK_LSB      2
`define MMS_ZX_LSB        4
`define MMS_SAMPLE_W      16
`endif

// *** core/mms_pkg.sv ***
// Types for the measurement-mode select block.
// Assumes mms_defines.svh is available on the include path.
package mms_pkg;
   // Phase code of a select field; 2'b11 is reserved
   typedef enum logic [1:0] {
      MMS_PH_A,
      MMS_PH_B,
      MMS_PH_C,
      MMS_PH_RSVD
   } mms_phase_e;
endpackage

// *** core/mms_peak_cmp.sv ***
// One peak comparator with a sticky flag.
// Assumes magnitudes arrive already synchronous to SYS_CLK.
`include "mms_defines.svh"
module mms_peak_cmp (
   input  wire logic                      clk,
   input  wire logic                      rst_n,
   input  wire logic [`MMS_SAMPLE_W-1:0]  sample,
   input  wire logic                      sample_ok,
   input  wire logic [`MMS_SAMPLE_W-1:0]  level,
   input  wire logic                      clr,
   output logic                           flag_ff
);
   logic hit; // Sample above programmed level

   assign hit = sample_ok && (sample > level);

   // Sticky flag; a hit in the clear cycle wins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_ff <= 1'b0;
      end else if (hit) begin
         flag_ff <= 1'b1;
      end else if (clr) begin
         flag_ff <= 1'b0;
      end
   end

   property p_set;
      @(posedge clk) disable iff (!rst_n) hit |=> flag_ff;
   endproperty
   a_set: assert property (p_set) else $error("peak flag not set after hit");
endmodule

// *** core/mms_mode_sel.sv ***
// Measurement-mode configuration register and its phase steering.
// Assumes register strobes and samples come from logic on SYS_CLK.
`include "mms_defines.svh"
module mms_mode_sel (
   input  wire logic                       SYS_CLK,
   input  wire logic                       RST_N,
   input  wire logic                       REG_WR,
   input  wire logic                       REG_RD,
   input  wire logic [`MMS_ADDR_W-1:0]     REG_ADDR,
   input  wire logic [7:0]                 REG_WDATA,
   output logic      [7:0]                 REG_RDATA,
   input  wire logic [3*`MMS_SAMPLE_W-1:0] V_MAG,
   input  wire logic [3*`MMS_SAMPLE_W-1:0] I_MAG,
   input  wire logic [`MMS_SAMPLE_W-1:0]   VOLTAGE_PEAK_LEVEL,
   input  wire logic [`MMS_SAMPLE_W-1:0]   CURRENT_PEAK_LEVEL,
   input  wire logic                       PEAK_FLAG_CLR,
   output logic                            VOLTAGE_PEAK_FLAG,
   output logic                            CURRENT_PEAK_FLAG,
   output logic      [1:0]                 PERIOD_PHASE_SELECT,
   output logic      [1:0]                 PEAK_PHASE_SELECT,
   output logic      [2:0]                 ZERO_CROSS_PHASE_ENABLE,
   input  wire logic [2:0]                 ZERO_CROSS_IN,
   output logic                            PERIOD_ZERO_CROSS
);
   logic [7:0]               cfg_ff;       // Register contents
   logic [7:0]               nxt_cfg;      // Next register value
   logic                     cfg_hit;      // Address decode
   logic [`MMS_SAMPLE_W-1:0] v_sel;        // Steered voltage
   logic [`MMS_SAMPLE_W-1:0] i_sel;        // Steered current
   logic                     sel_ok;       // Peak phase code valid
   logic [2:0]               zx_gated;     // Enabled crossings
   logic [2:0]               peak_oh;      // Peak select, one-hot

   // One decode serves both select fields
   // Shared phase decode; reserved code selects nothing
   function automatic logic [2:0] phase_onehot(input logic [1:0] code);
      case (mms_pkg::mms_phase_e'(code))
         mms_pkg::MMS_PH_A: phase_onehot = 3'h1;
         mms_pkg::MMS_PH_B: phase_onehot = 3'h2;
         mms_pkg::MMS_PH_C: phase_onehot = 3'h4;
         default:           phase_onehot = 3'h0;
      endcase
   endfunction

   assign cfg_hit = (REG_ADDR == `MMS_CFG_ADDR);

   // Bit 7 kept as written; software is expected to leave it 0
   always_comb begin
      nxt_cfg = cfg_ff;
      if (REG_WR && cfg_hit) begin
         nxt_cfg = REG_WDATA;
      end
   end

   // Reserved codes and bit 7 are stored exactly as written
   // Register with field defaults
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         cfg_ff <= `MMS_CFG_RESET;
      end else begin
         cfg_ff <= nxt_cfg;
      end
   end

   // A read in the write cycle still returns the old contents
   // Read data registered; unmapped addresses read zero
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         REG_RDATA <= 8'h00;
      end else if (REG_RD) begin
         REG_RDATA <= cfg_hit ? cfg_ff : 8'h00;
      end
   end

   assign PERIOD_PHASE_SELECT = cfg_ff[`MMS_PERD_LSB +: 2];
   assign PEAK_PHASE_SELECT = cfg_ff[`MMS_PEAK_LSB +: 2];
   assign ZERO_CROSS_PHASE_ENABLE = cfg_ff[`MMS_ZX_LSB +: 3];

   // Steering mux for peak inputs
   // Reserved code leaves both paths at zero and sel_ok low
   assign peak_oh = phase_onehot(PEAK_PHASE_SELECT);
   always_comb begin
      v_sel = '0;
      i_sel = '0;
      for (int k = 0; k < 3; k++) begin
         if (peak_oh[k]) begin
            v_sel = V_MAG[k*`MMS_SAMPLE_W +: `MMS_SAMPLE_W];
            i_sel = I_MAG[k*`MMS_SAMPLE_W +: `MMS_SAMPLE_W];
         end
      end
   end
   assign sel_ok = |peak_oh;

   mms_peak_cmp u_vpk (
      .clk       (SYS_CLK),
      .rst_n     (RST_N),
      .sample    (v_sel),
      .sample_ok (sel_ok),
      .level     (VOLTAGE_PEAK_LEVEL),
      .clr       (PEAK_FLAG_CLR),
      .flag_ff   (VOLTAGE_PEAK_FLAG)
   );

   mms_peak_cmp u_ipk (
      .clk       (SYS_CLK),
      .rst_n     (RST_N),
      .sample    (i_sel),
      .sample_ok (sel_ok),
      .level     (CURRENT_PEAK_LEVEL),
      .clr       (PEAK_FLAG_CLR),
      .flag_ff   (CURRENT_PEAK_FLAG)
   );

   // Gate crossings by enables
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_zx
         assign zx_gated[g] = ZERO_CROSS_IN[g] & ZERO_CROSS_PHASE_ENABLE[g];
      end
   endgenerate

   // Left combinational so the period engine sees the crossing in its own cycle
   // Period source crossing
   assign PERIOD_ZERO_CROSS = |(zx_gated & phase_onehot(PERIOD_PHASE_SELECT));

   property p_reset_val;
      @(posedge SYS_CLK) $rose(RST_N) |-> cfg_ff == `MMS_CFG_RESET;
   endproperty
   a_reset_val: assert property (p_reset_val) else $error("bad reset value");

   property p_write;
      @(posedge SYS_CLK) disable iff (!RST_N) REG_WR && cfg_hit |=> cfg_ff == $past(REG_WDATA);
   endproperty
   a_write: assert property (p_write) else $error("write not stored");

   property p_hold;
      @(posedge SYS_CLK) disable iff (!RST_N) !(REG_WR && cfg_hit) |=> $stable(cfg_ff);
   endproperty
   a_hold: assert property (p_hold) else $error("register changed without write");

   property p_rdata;
      @(posedge SYS_CLK) disable iff (!RST_N) REG_RD && cfg_hit |=> REG_RDATA == $past(cfg_ff);
   endproperty
   a_rdata: assert property (p_rdata) else $error("read data differs from register");

   property p_unmapped;
      @(posedge SYS_CLK) disable iff (!RST_N) REG_RD && !cfg_hit |=> REG_RDATA == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

   property p_perd;
      @(posedge SYS_CLK) disable iff (!RST_N)
         REG_WR && cfg_hit |=> PERIOD_PHASE_SELECT == $past(REG_WDATA[1:0]);
   endproperty
   a_perd: assert property (p_perd) else $error("period select mismatch");

   property p_perd_rsvd;
      @(posedge SYS_CLK) disable iff (!RST_N) PERIOD_PHASE_SELECT == 2'h3 |-> !PERIOD_ZERO_CROSS;
   endproperty
   a_perd_rsvd: assert property (p_perd_rsvd) else $error("crossing passed under reserved code");

   property p_peak;
      @(posedge SYS_CLK) disable iff (!RST_N)
         REG_WR && cfg_hit |=> PEAK_PHASE_SELECT == $past(REG_WDATA[3:2]);
   endproperty
   a_peak: assert property (p_peak) else $error("peak select mismatch");

   property p_peak_rsvd;
      @(posedge SYS_CLK) disable iff (!RST_N)
         PEAK_PHASE_SELECT == 2'h3 && !VOLTAGE_PEAK_FLAG && !CURRENT_PEAK_FLAG |=>
         !VOLTAGE_PEAK_FLAG && !CURRENT_PEAK_FLAG;
   endproperty
   a_peak_rsvd: assert property (p_peak_rsvd) else $error("flag set under reserved code");

   property p_vpk;
      @(posedge SYS_CLK) disable iff (!RST_N) sel_ok && v_sel > VOLTAGE_PEAK_LEVEL |=> VOLTAGE_PEAK_FLAG;
   endproperty
   a_vpk: assert property (p_vpk) else $error("voltage peak flag missed");

   property p_vclr;
      @(posedge SYS_CLK) disable iff (!RST_N)
         PEAK_FLAG_CLR && !(sel_ok && v_sel > VOLTAGE_PEAK_LEVEL) |=> !VOLTAGE_PEAK_FLAG;
   endproperty
   a_vclr: assert property (p_vclr) else $error("voltage peak flag not cleared");

   property p_ipk;
      @(posedge SYS_CLK) disable iff (!RST_N) sel_ok && i_sel > CURRENT_PEAK_LEVEL |=> CURRENT_PEAK_FLAG;
   endproperty
   a_ipk: assert property (p_ipk) else $error("current peak flag missed");

   property p_zx;
      @(posedge SYS_CLK) disable iff (!RST_N) PERIOD_ZERO_CROSS |-> |(ZERO_CROSS_IN & ZERO_CROSS_PHASE_ENABLE);
   endproperty
   a_zx: assert property (p_zx) else $error("crossing passed while disabled");

   property p_zxb;
      @(posedge SYS_CLK) disable iff (!RST_N)
         REG_WR && cfg_hit |=> ZERO_CROSS_PHASE_ENABLE == $past(REG_WDATA[6:4]);
   endproperty
   a_zxb: assert property (p_zxb) else $error("zero-cross enable mismatch");

   c_write: cover property (@(posedge SYS_CLK) disable iff (!RST_N) REG_WR && cfg_hit);
   c_rsvd:  cover property (@(posedge SYS_CLK) disable iff (!RST_N) PEAK_PHASE_SELECT == 2'h3);
   c_vpk:   cover property (@(posedge SYS_CLK) disable iff (!RST_N) $rose(VOLTAGE_PEAK_FLAG));
   c_ipk:   cover property (@(posedge SYS_CLK) disable iff (!RST_N) $rose(CURRENT_PEAK_FLAG));
   c_zx:    cover property (@(posedge SYS_CLK) disable iff (!RST_N) PERIOD_ZERO_CROSS);
endmodule

// *** dv/tb_mms_mode_sel.sv ***
// Self-checking bench for the measurement-mode select block.
// Assumes core/ sources compiled first and mms_defines.svh on the path.
`include "mms_defines.svh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin error_cnt++; \
$display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module tb_mms_mode_sel;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst_n, wr, rd, clr;   // Clock, reset, strobes
   logic [5:0]  addr;                      // Register address
   logic [7:0]  wdata, rdata;              // Register data
   logic [47:0] vmag, imag;                // Phase magnitudes
   logic [15:0] vlvl, ilvl;                // Peak thresholds
   logic        vflag, iflag, pzc;         // Flags, period crossing
   logic [1:0]  psel, ksel;                // Phase selects
   logic [2:0]  zen, zin;                  // Crossing enables, inputs
   int          error_cnt, total_checks;   // Verdict counters
   int          cyc, cfg, s, h;            // Timeout, model state
   mms_mode_sel i_mms_mode_sel (
      .SYS_CLK(clk), .RST_N(rst_n), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr),
      .REG_WDATA(wdata), .REG_RDATA(rdata), .V_MAG(vmag), .I_MAG(imag),
      .VOLTAGE_PEAK_LEVEL(vlvl), .CURRENT_PEAK_LEVEL(ilvl), .PEAK_FLAG_CLR(clr),
      .VOLTAGE_PEAK_FLAG(vflag), .CURRENT_PEAK_FLAG(iflag),
      .PERIOD_PHASE_SELECT(psel), .PEAK_PHASE_SELECT(ksel),
      .ZERO_CROSS_PHASE_ENABLE(zen), .ZERO_CROSS_IN(zin), .PERIOD_ZERO_CROSS(pzc));
   // 200 MHz clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Hang guard, far above the few hundred cycles needed
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         conclude();
      end
   end
   task automatic conclude();
      if (error_cnt == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // One write cycle, strobe dropped at the next edge
   task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // Read data is registered, so look just after the sampling edge
   task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 `CHK(rdata, e)
   endtask
   // Field outputs against the model; code 3 gives no period crossing
   task automatic chk_cfg();
      h = cfg & 3;
      `CHK(psel, cfg[1:0])
      `CHK(ksel, cfg[3:2])
      `CHK(zen, cfg[6:4])
      `CHK(pzc, (h != 3) && zin[h] && cfg[4+h])
   endtask
   initial begin
      {rst_n, wr, rd, clr, addr, wdata, zin} = '0;
      {vmag, imag} = '0;
      vlvl = 16'h8000;
      ilvl = 16'h8000;
      void'($urandom(94));
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      cfg = 'h70;
      #1 chk_cfg();
      rd_chk(`MMS_CFG_ADDR, 8'h70);
      // Random configs, stray writes to unmapped places, crossing pulses
      repeat (24) begin
         s = $urandom;
         // Bit 7 clear, reserved codes avoided
         cfg = s & 'h7F;
         if ((cfg & 'h3) == 'h3) cfg = cfg ^ 'h1;
         if ((cfg & 'hC) == 'hC) cfg = cfg ^ 'h4;
         wr_reg(`MMS_CFG_ADDR, cfg[7:0]);
         wr_reg((s[13:8] == 6'h0B) ? 6'h3F : s[13:8], ~s[7:0]);
         rd_chk((s[13:8] == 6'h0B) ? 6'h3F : s[13:8], 8'h00);
         rd_chk(`MMS_CFG_ADDR, cfg[7:0]);
         @(posedge clk);
         zin <= 3'($urandom);
         #1 chk_cfg();
      end
      // Mid-run reset brings the defaults back
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      cfg = 'h70;
      #1 chk_cfg();
      `CHK(rdata, 8'h00)
      rd_chk(`MMS_CFG_ADDR, 8'h70);
      // Peak hit on each phase under every select code; the last pass probes the reserved codes
      for (int k = 0; k < 4; k++) begin
         for (int p = 0; p < 3; p++) begin
            cfg = 'h70 | (k << 2) | ((k == 3) ? 3 : 0);
            wr_reg(`MMS_CFG_ADDR, cfg[7:0]);
            @(posedge clk);
            vlvl <= 16'($urandom_range(16'hFFFE, 1));
            ilvl <= 16'($urandom_range(16'hFFFE, 1));
            vmag <= '0;
            imag <= '0;
            zin <= 3'h7;
            @(posedge clk);
            clr <= 1'b1;
            @(posedge clk);
            clr <= 1'b0;
            vmag <= {32'h0, vlvl + 16'h1} << (16 * p);
            imag <= {32'h0, ilvl + 16'h1} << (16 * p);
            repeat (2) @(posedge clk);
            #1 `CHK(vflag, k == p)
            `CHK(iflag, k == p)
            chk_cfg();
            // Clear while the hit still stands: the set wins
            @(posedge clk);
            clr <= 1'b1;
            @(posedge clk);
            clr <= 1'b0;
            #1 `CHK(vflag, k == p)
            `CHK(iflag, k == p)
         end
      end
      conclude();
   end
endmodule
